//--- logic/hwm_pkg.sv
// Package of constants and types for the 8x8 hardware multiplier datapath
// Operation
// - Literal multiply: working register times immediate
// - Full 16-bit product split high/low bytes
// - File multiply: working register times addressed register
// - File multiply leaves both source operands unchanged
// - Multiplies never touch any status flag
`default_nettype none
package hwm_pkg;

   // Operand and product widths
   localparam int OPW   = 8;
   localparam int PRODW = 16;

   // Phase sequence within one instruction cycle
   typedef enum logic [1:0] {
      HWM_PH_DECODE  = 2'b00,
      HWM_PH_READ    = 2'b01,
      HWM_PH_EXECUTE = 2'b10,
      HWM_PH_WRITE   = 2'b11
   } hwm_phase_t;

   // Instruction selector from the decoder
   typedef enum logic [1:0] {
      HWM_OP_NONE    = 2'b00,
      HWM_OP_LITERAL = 2'b01,
      HWM_OP_FILE    = 2'b10
   } hwm_op_t;

   // Values after reset
   localparam logic [7:0] PROD_RESET   = 8'h00;
   localparam logic [7:0] FACTOR_RESET = 8'h00;
   // Last phase of one instruction cycle
   localparam logic [1:0] PHASE_LAST   = 2'h3;

endpackage : hwm_pkg
`default_nettype wire

//--- logic/hwm_multiplier.sv
// Single-cycle 8x8 unsigned multiplier with product register pair
`timescale 1ns/1ns
`default_nettype none
module hwm_multiplier (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Decoder request, sampled in the decode phase
   input  wire logic             start,
   input  wire hwm_pkg::hwm_op_t op,
   input  wire logic [7:0]       literal_k,
   // Working register and addressed file register (read only)
   input  wire logic [7:0]       working_register,
   input  wire logic [7:0]       file_data,
   // Product register pair and phase indication
   output logic [7:0]            product_high,
   output logic [7:0]            product_low,
   output logic                  product_write,
   output logic                  busy,
   output var hwm_pkg::hwm_phase_t phase
);

   hwm_pkg::hwm_op_t   op_reg;
   logic [7:0]         lit_reg;
   logic [7:0]         fa_reg;
   logic [7:0]         fb_reg;
   logic [15:0]        prod_reg;
   logic [15:0]        prod_next;

   // Phase sequencer: decode, read, execute, write, then idle again
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase <= hwm_pkg::HWM_PH_DECODE;
         busy  <= 1'b0;
      end
      else if (busy)
      begin
         phase <= hwm_pkg::hwm_phase_t'(phase + 2'h1);
         busy  <= (phase != hwm_pkg::PHASE_LAST);
      end
      else if (start && op != hwm_pkg::HWM_OP_NONE)
      begin
         phase <= hwm_pkg::HWM_PH_READ;
         busy  <= 1'b1;
      end
   end

   // Decode: latch which instruction and its literal
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_reg  <= hwm_pkg::HWM_OP_NONE;
         lit_reg <= hwm_pkg::FACTOR_RESET;
      end
      else if (!busy && start)
      begin
         op_reg  <= op;
         lit_reg <= literal_k;
      end
   end

   // Operand read phase; sources are only sampled, never written back
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fa_reg <= hwm_pkg::FACTOR_RESET;
         fb_reg <= hwm_pkg::FACTOR_RESET;
      end
      else if (busy && phase == hwm_pkg::HWM_PH_READ)
      begin
         fa_reg <= working_register;
         case (op_reg)
            hwm_pkg::HWM_OP_LITERAL: fb_reg <= lit_reg;
            hwm_pkg::HWM_OP_FILE:    fb_reg <= file_data;
            default:                 fb_reg <= hwm_pkg::FACTOR_RESET;
         endcase
      end
   end

   // Execute: zero-extended operands, so the product never overflows 16 bits
   always_comb
   begin
      prod_next = 16'({8'h00, fa_reg} * {8'h00, fb_reg});
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prod_reg <= {hwm_pkg::PROD_RESET, hwm_pkg::PROD_RESET};
      else if (busy && phase == hwm_pkg::HWM_PH_EXECUTE)
         prod_reg <= prod_next;
   end

   // Write phase: only the product pair changes; no flag output exists
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         product_high  <= hwm_pkg::PROD_RESET;
         product_low   <= hwm_pkg::PROD_RESET;
         product_write <= 1'b0;
      end
      else
      begin
         product_write <= busy && phase == hwm_pkg::HWM_PH_WRITE;
         if (busy && phase == hwm_pkg::HWM_PH_WRITE)
         begin
            product_high <= prod_reg[15:8];
            product_low  <= prod_reg[7:0];
         end
      end
   end

   // Assertions
   property p_seq;
      @(posedge clk) disable iff (!rst_n)
      (!busy && start && op != hwm_pkg::HWM_OP_NONE) |-> ##4 product_write;
   endproperty
   a_seq: assert property (p_seq) else $error("product not written 4 cycles after start");

   property p_lit;
      @(posedge clk) disable iff (!rst_n)
      (!busy && start && op == hwm_pkg::HWM_OP_LITERAL) ##1 1'b1
      |-> ##4 ({product_high, product_low} ==
               {8'h00, $past(working_register, 4)} * {8'h00, $past(literal_k, 5)});
   endproperty
   a_lit: assert property (p_lit) else $error("literal product wrong");

   property p_file;
      @(posedge clk) disable iff (!rst_n)
      (!busy && start && op == hwm_pkg::HWM_OP_FILE) ##1 1'b1
      |-> ##4 ({product_high, product_low} ==
               {8'h00, $past(working_register, 4)} * {8'h00, $past(file_data, 4)});
   endproperty
   a_file: assert property (p_file) else $error("file product wrong");

   property p_split;
      @(posedge clk) disable iff (!rst_n)
      product_write |-> product_high == $past(prod_reg[15:8]) && product_low == $past(prod_reg[7:0]);
   endproperty
   a_split: assert property (p_split) else $error("product bytes swapped");

   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      !product_write |-> $stable(product_high) && $stable(product_low);
   endproperty
   a_hold: assert property (p_hold) else $error("product changed outside write");

   // Decode is the request cycle itself, so busy covers read, execute and write only
   property p_busy;
      @(posedge clk) disable iff (!rst_n)
      $rose(busy) |-> busy[*3] ##1 !busy;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not three phases");

   // Every busy cycle advances exactly one phase; a late start cannot restart it
   property p_step;
      @(posedge clk) disable iff (!rst_n)
      busy |=> phase == hwm_pkg::hwm_phase_t'($past(phase) + 2'h1);
   endproperty
   a_step: assert property (p_step) else $error("phase did not advance by one");

   // Outside an instruction the sequencer rests in decode
   property p_idle;
      @(posedge clk) disable iff (!rst_n)
      !busy |-> phase == hwm_pkg::HWM_PH_DECODE;
   endproperty
   a_idle: assert property (p_idle) else $error("idle but phase not decode");

   // Requests are refused while busy, so write pulses never come back to back
   property p_pulse;
      @(posedge clk) disable iff (!rst_n)
      product_write |=> !product_write;
   endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse longer than one cycle");

   // The pair is only written out of the write phase
   property p_wsrc;
      @(posedge clk) disable iff (!rst_n)
      product_write |-> $past(busy) && $past(phase) == hwm_pkg::HWM_PH_WRITE;
   endproperty
   a_wsrc: assert property (p_wsrc) else $error("write outside write phase");

   // A start while busy must not disturb the instruction already latched
   property p_refuse;
      @(posedge clk) disable iff (!rst_n)
      (busy && start) |=> $stable(op_reg) && $stable(lit_reg);
   endproperty
   a_refuse: assert property (p_refuse) else $error("busy request was taken");

   // Read phase captures the working register as it stands, never a later value
   property p_working_register;
      @(posedge clk) disable iff (!rst_n)
      (busy && phase == hwm_pkg::HWM_PH_READ) |=> fa_reg == $past(working_register);
   endproperty
   a_working_register: assert property (p_working_register) else $error("working register not captured");

   // File multiply takes its second factor from the addressed register
   property p_ffac;
      @(posedge clk) disable iff (!rst_n)
      (busy && phase == hwm_pkg::HWM_PH_READ && op_reg == hwm_pkg::HWM_OP_FILE)
      |=> fb_reg == $past(file_data);
   endproperty
   a_ffac: assert property (p_ffac) else $error("file factor not captured");

   // Literal multiply takes its second factor from the immediate latched at decode
   property p_lfac;
      @(posedge clk) disable iff (!rst_n)
      (busy && phase == hwm_pkg::HWM_PH_READ && op_reg == hwm_pkg::HWM_OP_LITERAL)
      |=> fb_reg == $past(lit_reg);
   endproperty
   a_lfac: assert property (p_lfac) else $error("literal factor not captured");

   c_lit:  cover property (@(posedge clk) disable iff (!rst_n)
      start && op == hwm_pkg::HWM_OP_LITERAL && !busy);
   c_file: cover property (@(posedge clk) disable iff (!rst_n)
      start && op == hwm_pkg::HWM_OP_FILE && !busy);
   c_zero: cover property (@(posedge clk) disable iff (!rst_n)
      product_write && product_high == 8'h00 && product_low == 8'h00);
   // Refused request and a request right behind a finished one
   c_refuse: cover property (@(posedge clk) disable iff (!rst_n)
      busy && start && op != hwm_pkg::HWM_OP_NONE);
   c_b2b:    cover property (@(posedge clk) disable iff (!rst_n)
      product_write && start && op != hwm_pkg::HWM_OP_NONE);

endmodule : hwm_multiplier
`default_nettype wire

//--- test/hwm_regfile_model.sv
// Register file model that supplies the working register and file register factors to the multiplier
`timescale 1ns/1ns
`default_nettype none
module hwm_regfile_model (
   // Clock and load strobe from the bench
   input  wire logic       clk,
   input  wire logic       load,
   input  wire logic [7:0] w_in,
   input  wire logic [7:0] f_in,
   // Factors towards the multiplier
   output logic [7:0]      working_register,
   output logic [7:0]      file_data
);
   // Factors only change on load, so any write-back would show as a mismatch
   always_ff @(posedge clk)
   begin
      if (load)
      begin
         working_register <= w_in;
         file_data        <= f_in;
      end
   end
endmodule : hwm_regfile_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the 8x8 multiplier datapath
`timescale 1ns/1ns
`default_nettype none
module tb;
   // Clock, reset and decoder-side stimulus
   logic                clk         = 1'b0;
   logic                rst_n       = 1'b0;
   logic                start       = 1'b0;
   logic                load        = 1'b0;
   logic [7:0]          k           = 8'h00;
   logic [7:0]          w_in        = 8'h00;
   logic [7:0]          f_in        = 8'h00;
   hwm_pkg::hwm_op_t    op          = hwm_pkg::HWM_OP_NONE;
   // Factors from the register file model and the multiplier outputs
   logic [7:0]          wr;
   logic [7:0]          fd;
   logic [7:0]          ph;
   logic [7:0]          pl;
   logic                pw;
   logic                busy;
   hwm_pkg::hwm_phase_t phase;
   // Bookkeeping
   int                  bad_count   = 0;
   int                  checks_done = 0;
   int                  writes      = 0;

   // 50 ns period
   always #25 clk = ~clk;

   // Count write pulses mid-cycle, clear of the edge that launches them
   always @(negedge clk)
   begin
      if (pw === 1'b1)
         writes++;
   end

   hwm_regfile_model hwm_regfile_model_i (.clk(clk), .load(load), .w_in(w_in), .f_in(f_in),
      .working_register(wr), .file_data(fd));
   hwm_multiplier hwm_multiplier_i (.clk(clk), .rst_n(rst_n), .start(start), .op(op),
      .literal_k(k), .working_register(wr), .file_data(fd), .product_high(ph),
      .product_low(pl), .product_write(pw), .busy(busy), .phase(phase));

   // Mismatch report; the caller counts the comparison
   task fail_note(input string m);
      bad_count++;
      $display("unexpected %0t %s", $time, m);
   endtask : fail_note

   // One instruction phase by phase; poke holds a second start over the execute and write cycles
   task mul(input hwm_pkg::hwm_op_t o,
            input logic [7:0]       kk,
            input logic [7:0]       ww,
            input logic [7:0]       ff,
            input logic [15:0]      e,
            input logic             poke);
      int w0;
      begin
         @(posedge clk);
         load <= 1'b1;
         w_in <= ww;
         f_in <= ff;
         @(posedge clk);
         load  <= 1'b0;
         start <= 1'b1;
         op    <= o;
         k     <= kk;
         // Request taken at this edge
         @(posedge clk);
         start <= 1'b0;
         w0 = writes;
         @(negedge clk);
         checks_done++;
         if (phase !== hwm_pkg::HWM_PH_READ || busy !== 1'b1)
            fail_note("not in read phase");
         // Operands read here; a poke then stands over the two busy edges that follow
         @(posedge clk);
         start <= poke;
         op    <= hwm_pkg::HWM_OP_FILE;
         @(negedge clk);
         checks_done++;
         if (phase !== hwm_pkg::HWM_PH_EXECUTE || busy !== 1'b1)
            fail_note("not in execute phase");
         @(negedge clk);
         checks_done++;
         if (phase !== hwm_pkg::HWM_PH_WRITE || busy !== 1'b1 || pw !== 1'b0)
            fail_note("not in write phase");
         // Write edge; the poke must be gone before the idle edge samples it
         @(posedge clk);
         start <= 1'b0;
         @(negedge clk);
         checks_done++;
         if (pw !== 1'b1 || busy !== 1'b0 || phase !== hwm_pkg::HWM_PH_DECODE)
            fail_note("product not written after four phases");
         checks_done++;
         if ({ph, pl} !== e)
            fail_note("product value");
         checks_done++;
         if (wr !== ww || fd !== ff)
            fail_note("operand changed");
         repeat (6) @(negedge clk);
         checks_done++;
         if (writes != w0 + 1 || busy !== 1'b0 || {ph, pl} !== e)
            fail_note("refused start wrote");
      end
   endtask : mul

   task t_literal;
      mul(hwm_pkg::HWM_OP_LITERAL, 8'hc4, 8'he2, 8'h00, 16'had08, 1'b0);
      mul(hwm_pkg::HWM_OP_LITERAL, 8'h00, 8'h5a, 8'h33, 16'h0000, 1'b1);
   endtask : t_literal

   task t_file;
      mul(hwm_pkg::HWM_OP_FILE, 8'h00, 8'hc4, 8'hb5, 16'h8a94, 1'b0);
      mul(hwm_pkg::HWM_OP_FILE, 8'h12, 8'hff, 8'hff, 16'hfe01, 1'b1);
   endtask : t_file

   // A request without an operation must leave the product alone
   task t_none;
      int w0;
      begin
         w0 = writes;
         @(posedge clk);
         start <= 1'b1;
         op    <= hwm_pkg::HWM_OP_NONE;
         @(posedge clk);
         start <= 1'b0;
         repeat (6) @(negedge clk);
         checks_done++;
         if (writes != w0 || busy !== 1'b0 || {ph, pl} !== 16'hfe01)
            fail_note("none op wrote");
      end
   endtask : t_none

   // Reset in mid-instruction drops it; a fresh instruction must then run normally
   task t_reset;
      int w0;
      begin
         w0 = writes;
         @(posedge clk);
         start <= 1'b1;
         op    <= hwm_pkg::HWM_OP_LITERAL;
         k     <= 8'h03;
         @(posedge clk);
         start <= 1'b0;
         @(posedge clk);
         rst_n <= 1'b0;
         @(negedge clk);
         checks_done++;
         if ({ph, pl} !== {hwm_pkg::PROD_RESET, hwm_pkg::PROD_RESET} || pw !== 1'b0)
            fail_note("product not cleared by reset");
         checks_done++;
         if (busy !== 1'b0 || phase !== hwm_pkg::HWM_PH_DECODE)
            fail_note("sequencer not idle in reset");
         @(posedge clk);
         rst_n <= 1'b1;
         repeat (6) @(negedge clk);
         checks_done++;
         if (writes != w0 || busy !== 1'b0 || {ph, pl} !== {hwm_pkg::PROD_RESET, hwm_pkg::PROD_RESET})
            fail_note("dropped instruction wrote");
         mul(hwm_pkg::HWM_OP_LITERAL, 8'h03, 8'h81, 8'h00, 16'h0183, 1'b0);
      end
   endtask : t_reset

   task results;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_literal;
      t_file;
      t_none;
      t_reset;
      results;
   end

   // About 80 cycles of work, so 2000 cycles means a hang
   initial
   begin
      #100000;
      bad_count++;
      results;
   end
endmodule : tb
`default_nettype wire
